// File: src/autoneg_pkg.sv
// Package: register map, field layout and reset values of the negotiation register set
package autoneg_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [3:0] IDX_ID_TWO = 4'h3;
  localparam logic [3:0] IDX_ADVERT = 4'h4;
  localparam logic [3:0] IDX_PARTNER = 4'h5;
  localparam logic [3:0] IDX_EXPANSION = 4'h6;
  localparam logic [3:0] IDX_NEXT_PAGE = 4'h7;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 6;

  // ==========================================================
  // Field positions
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_REMOTE_FAULT = 13;
  localparam int ADV_ASYM_PAUSE = 11;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_ABIL_HI = 8;
  localparam int ADV_ABIL_LO = 5;
  localparam int SEL_HI = 4;
  localparam int LP_ACK = 14;
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_LOC_NP_ABLE = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LP_AN_ABLE = 0;
  localparam int NP_MORE = 15;
  localparam int NP_MESSAGE = 13;
  localparam int NP_CODE_HI = 10;

  // ==========================================================
  // Reset values and masks
  localparam logic [4:0] SELECTOR_RST = 5'h01;
  localparam logic [10:0] NULL_CODE_RST = 11'h001;
  localparam logic [15:0] ADVERT_WMASK = 16'hADFF;
  localparam logic [15:0] PARTNER_MASK = 16'hAFFF;
  localparam logic [15:0] NEXT_PAGE_WMASK = 16'hA7FF;
  localparam logic [15:0] NEXT_PAGE_RST = 16'h2001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Page events from the negotiation engine
  typedef struct packed {
    logic base_page_valid;
    logic [15:0] base_page;
    logic partner_acked;
    logic page_received;
    logic pd_fault;
    logic partner_an_able;
    logic restart;
  } page_event_t;

endpackage

// File: src/autoneg_register_set.sv
// Negotiation register set behind an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module autoneg_register_set
  import autoneg_pkg::*;
#(
  parameter logic [5:0] OUI_LOW = 6'h15,  // Arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h2A,  // Arbitrary value
  parameter logic [3:0] REVISION = 4'h5  // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] strap_ability,
  input wire page_event_t page_evt,
  output logic [15:0] advert_word,
  output logic [15:0] next_page_word
);

  // ==========================================================
  // Strap synchroniser, sampled once after reset release
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic strap_pending_r;

  always_ff @(posedge aclk) begin
    strap_s1_r <= strap_ability;
    strap_s2_r <= strap_s1_r;
  end

  // ==========================================================
  // Write channel: address and data latched in either order
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held_r && w_held_r && !bvalid_r;
  wire [3:0] wr_idx = 4'(aw_addr_r >> ADDR_LSB);
  wire [15:0] wr_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire wr_adv = do_write && wr_idx == IDX_ADVERT;
  wire wr_np = do_write && wr_idx == IDX_NEXT_PAGE;
  wire wr_known = wr_idx >= IDX_ID_TWO && wr_idx <= IDX_NEXT_PAGE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Writable registers
  logic [15:0] advert_r;
  logic [15:0] next_page_r;
  wire [15:0] adv_merge = (advert_r & ~wr_mask) | (w_data_r[15:0] & wr_mask);
  wire [15:0] np_merge = (next_page_r & ~wr_mask) | (w_data_r[15:0] & wr_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      advert_r <= {11'h00F, SELECTOR_RST};
      next_page_r <= NEXT_PAGE_RST;
      strap_pending_r <= 1'b1;
    end else begin
      strap_pending_r <= 1'b0;
      if (wr_adv) begin
        advert_r <= adv_merge & ADVERT_WMASK;
      end else if (strap_pending_r) begin
        advert_r[ADV_ABIL_HI:ADV_ABIL_LO] <= strap_s2_r;
      end
      if (wr_np) begin
        next_page_r <= np_merge & NEXT_PAGE_WMASK;
      end
    end
  end

  // ==========================================================
  // Read channel; one cycle from address to data
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire ar_take = s_axi_arvalid && arready_r;
  wire [3:0] rd_idx = 4'(s_axi_araddr >> ADDR_LSB);
  wire rd_exp = ar_take && rd_idx == IDX_EXPANSION;

  // ==========================================================
  // Partner ability and expansion status
  logic [15:0] partner_r;
  logic pd_fault_r;
  logic page_rx_r;
  logic lp_np_able_r;
  logic lp_an_able_r;

  wire [15:0] partner_nxt = page_evt.base_page & PARTNER_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn || page_evt.restart) begin
      partner_r <= '0;
      lp_np_able_r <= 1'b0;
      lp_an_able_r <= 1'b0;
    end else begin
      if (page_evt.base_page_valid) begin
        partner_r <= partner_nxt;
        lp_np_able_r <= page_evt.base_page[ADV_NEXT_PAGE];
      end
      partner_r[LP_ACK] <= page_evt.partner_acked;
      if (page_evt.partner_an_able) begin
        lp_an_able_r <= 1'b1;
      end
    end
  end

  // Set wins over the read clear so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_fault_r <= 1'b0;
      page_rx_r <= 1'b0;
    end else begin
      pd_fault_r <= page_evt.pd_fault || (pd_fault_r && !rd_exp);
      page_rx_r <= page_evt.page_received || (page_rx_r && !rd_exp);
    end
  end

  wire [15:0] id_two_val = {OUI_LOW, MODEL_NUM, REVISION};
  wire [15:0] expansion_val = {11'h000, pd_fault_r, lp_np_able_r, 1'b1,
                               page_rx_r, lp_an_able_r};
  logic [15:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_ID_TWO: rd_word = id_two_val;
      IDX_ADVERT: rd_word = advert_r;
      IDX_PARTNER: rd_word = partner_r;
      IDX_EXPANSION: rd_word = expansion_val;
      IDX_NEXT_PAGE: rd_word = next_page_r;
      default: begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_word};
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  logic awready_r;
  logic wready_r;
  logic [15:0] advert_out_r;
  logic [15:0] np_out_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      advert_out_r <= '0;
      np_out_r <= '0;
    end else begin
      awready_r <= !aw_held_r && !aw_take && !bvalid_r;
      wready_r <= !w_held_r && !w_take && !bvalid_r;
      advert_out_r <= advert_r;
      np_out_r <= next_page_r;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign advert_word = advert_out_r;
  assign next_page_word = np_out_r;

  // ==========================================================
  // Assertions
  a_adv_t4_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    advert_r[9] == 1'b0 && advert_r[14] == 1'b0 && advert_r[12] == 1'b0)
    else $error("advert reserved or T4 bit set");

  a_adv_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_adv && w_strb_r[1] |=> advert_r[ADV_NEXT_PAGE] == $past(w_data_r[15]))
    else $error("advert next page not written");

  a_adv_rf_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_adv && w_strb_r[1] |=> advert_r[ADV_REMOTE_FAULT] == $past(w_data_r[13]))
    else $error("advert remote fault not written");

  a_pause_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_adv && w_strb_r[1] |=> advert_r[ADV_PAUSE] == $past(w_data_r[10]))
    else $error("advert pause not written");

  a_asym_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_adv && w_strb_r[1] |=> advert_r[ADV_ASYM_PAUSE] == $past(w_data_r[11]))
    else $error("advert asymmetric pause not written");

  a_abil_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_adv && w_strb_r[1] && w_strb_r[0]
    |=> advert_r[ADV_ABIL_HI:ADV_ABIL_LO] == $past(w_data_r[8:5]))
    else $error("advert speed abilities not written");

  a_sel_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_adv && w_strb_r[0] |=> advert_r[SEL_HI:0] == $past(w_data_r[4:0]))
    else $error("selector not written");

  a_adv_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_idx == IDX_ADVERT |=> (rdata_r[15:0] & 16'h5200) == 16'h0000)
    else $error("advert read shows fixed zero bits set");

  a_adv_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> advert_r[15:9] == 7'h00 && advert_r[SEL_HI:0] == SELECTOR_RST)
    else $error("advert reset value wrong");

  a_strap_load: assert property (@(posedge aclk)
    $rose(aresetn) ##0 !wr_adv |=> advert_r[ADV_ABIL_HI:ADV_ABIL_LO] == $past(strap_s2_r))
    else $error("strap not loaded");

  a_page_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    page_evt.page_received |=> page_rx_r)
    else $error("page received not latched");

  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_exp && !page_evt.page_received && !page_evt.pd_fault |=> !page_rx_r && !pd_fault_r)
    else $error("latched bits not cleared on read");

  a_fault_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    page_evt.pd_fault |=> pd_fault_r)
    else $error("parallel fault not latched");

  a_partner_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
    page_evt.base_page_valid && !page_evt.restart
    |=> partner_r[15] == $past(page_evt.base_page[15])
        && partner_r[13] == $past(page_evt.base_page[13]))
    else $error("partner page not mirrored");

  a_partner_fields: assert property (@(posedge aclk) disable iff (!aresetn)
    page_evt.base_page_valid && !page_evt.restart
    |=> partner_r[11:0] == $past(page_evt.base_page[11:0]) && !partner_r[12])
    else $error("partner ability fields not mirrored");

  a_partner_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    !page_evt.restart |=> partner_r[LP_ACK] == $past(page_evt.partner_acked))
    else $error("partner ack not shown");

  a_restart_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    page_evt.restart |=> partner_r == 16'h0000 && !lp_an_able_r)
    else $error("partner not cleared on restart");

  a_lp_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> partner_r == 16'h0000 && !pd_fault_r && !page_rx_r)
    else $error("partner or latched bits not reset");

  a_exp_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    expansion_val[EXP_LOC_NP_ABLE] && expansion_val[15:5] == 11'h000)
    else $error("expansion fixed bits wrong");

  a_exp_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_idx == IDX_EXPANSION
    |=> rdata_r[15:5] == 11'h000 && rdata_r[EXP_LOC_NP_ABLE])
    else $error("expansion read fixed bits wrong");

  a_np_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_np && w_strb_r[1]
    |=> next_page_r[NP_MESSAGE] == $past(w_data_r[13]) && !next_page_r[14])
    else $error("next page write wrong");

  a_np_more: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_np && w_strb_r[1] |=> next_page_r[NP_MORE] == $past(w_data_r[15]))
    else $error("next page more flag not written");

  a_np_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> !next_page_r[NP_MORE] && next_page_r[NP_MESSAGE])
    else $error("next page flags reset wrong");

  a_lp_np_able: assert property (@(posedge aclk) disable iff (!aresetn)
    page_evt.base_page_valid && !page_evt.restart
    |=> lp_np_able_r == $past(page_evt.base_page[15]))
    else $error("partner next page ability wrong");

  a_an_able: assert property (@(posedge aclk) disable iff (!aresetn)
    page_evt.partner_an_able && !page_evt.restart |=> lp_an_able_r)
    else $error("partner negotiation ability not set");

  a_id_fields: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_idx == IDX_ID_TWO |=> rdata_r[15:0] == {OUI_LOW, MODEL_NUM, REVISION})
    else $error("identifier word wrong");

  a_code_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> next_page_r[NP_CODE_HI:0] == NULL_CODE_RST)
    else $error("next page code reset wrong");

endmodule

// File: tb/link_partner_model.sv
// Behavioural far-side model: delivers received pages and negotiation events
`timescale 1ns/1ns
module link_partner_model
  import autoneg_pkg::*;
(
  input wire logic aclk,
  output page_event_t page_evt
);
  initial page_evt = '0;

  // ==========================================================
  // Page delivery
  // Word lines show the inverse once the strobe is gone, never a stale page
  task automatic send_page(input logic [15:0] w, input logic fault);
    @(posedge aclk);
    page_evt.base_page <= w;
    page_evt.base_page_valid <= 1'b1;
    page_evt.page_received <= 1'b1;
    page_evt.partner_an_able <= 1'b1;
    page_evt.pd_fault <= fault;
    @(posedge aclk);
    page_evt.base_page <= ~w;
    page_evt.base_page_valid <= 1'b0;
    page_evt.page_received <= 1'b0;
    page_evt.partner_an_able <= 1'b0;
    page_evt.pd_fault <= 1'b0;
  endtask

  task automatic set_ack(input logic v);
    @(posedge aclk);
    page_evt.partner_acked <= v;
  endtask

  task automatic restart();
    @(posedge aclk);
    page_evt.restart <= 1'b1;
    @(posedge aclk);
    page_evt.restart <= 1'b0;
  endtask
endmodule

// File: tb/autoneg_register_set_tb_top.sv
// Self-checking bench for the negotiation register set
`timescale 1ns/1ns
module autoneg_register_set_tb_top;
  import autoneg_pkg::*;
  localparam logic [15:0] ID_EXP = {6'h15, 6'h2A, 4'h5};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [3:0] strap = 4'hA;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] advert_word, next_page_word, seed, v;
  page_event_t page_evt;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];

  always #5 aclk = ~aclk;

  autoneg_register_set u_autoneg_register_set (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .strap_ability(strap), .page_evt(page_evt),
    .advert_word(advert_word), .next_page_word(next_page_word)
  );

  link_partner_model u_link_partner_model (.aclk(aclk), .page_evt(page_evt));

  // ==========================================================
  // Comparison and reporting
  task automatic chk_r(input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t read got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_b(input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t write response got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_w(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t word output got %h want %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    // A note never answered means a lost response
    if (exp_r.size() != 0 || exp_b.size() != 0) n_errors++;
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Monitor: responses are matched against the oldest note
  always @(posedge aclk) begin
    cycles++;
    if (rvalid === 1'b1 && rready) chk_r(exp_r.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready) chk_b(exp_b.pop_front(), bresp);
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // ==========================================================
  // Bus master
  task automatic wr(input logic [3:0] idx, input logic [15:0] d, input logic [1:0] e);
    exp_b.push_back(e);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [15:0] d, input logic [1:0] e);
    exp_r.push_back({e, 16'h0000, d});
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    seed = 16'h0010;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(IDX_ID_TWO, ID_EXP, RESP_OKAY);
    rd(IDX_ADVERT, 16'h0141, RESP_OKAY);
    rd(IDX_PARTNER, 16'h0000, RESP_OKAY);
    rd(IDX_EXPANSION, 16'h0004, RESP_OKAY);
    rd(IDX_NEXT_PAGE, 16'h2001, RESP_OKAY);
    wr(IDX_ADVERT, 16'hFFFF, RESP_OKAY);
    rd(IDX_ADVERT, 16'hADFF, RESP_OKAY);
    chk_w(16'hADFF, advert_word);
    wr(IDX_NEXT_PAGE, 16'hEFFF, RESP_OKAY);
    rd(IDX_NEXT_PAGE, 16'hA7FF, RESP_OKAY);
    chk_w(16'hA7FF, next_page_word);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(IDX_ADVERT, seed, RESP_OKAY);
      rd(IDX_ADVERT, seed & 16'hADFF, RESP_OKAY);
      wr(IDX_NEXT_PAGE, seed & 16'hEFFF, RESP_OKAY);
      rd(IDX_NEXT_PAGE, seed & 16'hA7FF, RESP_OKAY);
    end
    // Low byte strobe only: the upper byte must keep its value
    wstrb <= 4'h1;
    wr(IDX_ADVERT, 16'h0000, RESP_OKAY);
    wstrb <= 4'hF;
    rd(IDX_ADVERT, seed & 16'hAD00, RESP_OKAY);
    // Read-only words must ignore writes, unmapped ones answer with an error
    wr(IDX_ID_TWO, 16'h0000, RESP_OKAY);
    wr(IDX_PARTNER, 16'hFFFF, RESP_OKAY);
    wr(IDX_EXPANSION, 16'hFFFF, RESP_OKAY);
    rd(IDX_ID_TWO, ID_EXP, RESP_OKAY);
    rd(IDX_PARTNER, 16'h0000, RESP_OKAY);
    rd(IDX_EXPANSION, 16'h0004, RESP_OKAY);
    wr(4'h8, 16'hFFFF, RESP_SLVERR);
    rd(4'h8, 16'h0000, RESP_SLVERR);
    rd(4'h0, 16'h0000, RESP_SLVERR);
    u_link_partner_model.set_ack(1'b1);
    u_link_partner_model.send_page(16'hFFFF, 1'b1);
    rd(IDX_PARTNER, 16'hEFFF, RESP_OKAY);
    rd(IDX_EXPANSION, 16'h001F, RESP_OKAY);
    rd(IDX_EXPANSION, 16'h000D, RESP_OKAY);
    u_link_partner_model.set_ack(1'b0);
    seed = lfsr(seed);
    v = seed & 16'h7FFF;
    u_link_partner_model.send_page(v, 1'b0);
    rd(IDX_PARTNER, v & 16'h2FFF, RESP_OKAY);
    rd(IDX_EXPANSION, 16'h0007, RESP_OKAY);
    u_link_partner_model.restart();
    rd(IDX_PARTNER, 16'h0000, RESP_OKAY);
    rd(IDX_EXPANSION, 16'h0004, RESP_OKAY);
    // Second reset with other straps and dirty registers
    wr(IDX_NEXT_PAGE, 16'h0000, RESP_OKAY);
    rd(IDX_NEXT_PAGE, 16'h0000, RESP_OKAY);
    strap <= 4'h5;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(IDX_ADVERT, 16'h00A1, RESP_OKAY);
    chk_w(16'h00A1, advert_word);
    rd(IDX_NEXT_PAGE, 16'h2001, RESP_OKAY);
    chk_w(16'h2001, next_page_word);
    repeat (2) @(posedge aclk);
    conclude();
  end
endmodule
